// ### core/pfs_pkg.sv
// Shared constants for the programmable CPU frequency select block
package pfs_pkg;

  // ==========================================================================
  // Register offsets on the byte register port
  localparam logic [7:0] OFS_DIV_N = 8'h0D;
  localparam logic [7:0] OFS_DIV_M = 8'h0E;
  localparam logic [7:0] OFS_RSVD_A = 8'h0F;
  localparam logic [7:0] OFS_RSVD_B = 8'h10;
  localparam logic [7:0] OFS_RSVD_C = 8'h11;
  localparam logic [7:0] OFS_SEL_CTRL = 8'h12;

  // ==========================================================================
  // Field positions
  localparam int unsigned POS_PROG_EN = 7;
  localparam int unsigned POS_OVERRIDE = 7;
  localparam int unsigned POS_BUSY = 6;
  localparam int unsigned POS_RANGE_ERR = 5;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_DIV_N = 8'h00;
  localparam logic [7:0] RST_DIV_M = 8'h00;
  localparam logic [7:0] RST_RSVD_A = 8'h03;
  localparam logic [7:0] RST_RSVD_B = 8'h00;
  localparam logic [7:0] RST_RSVD_C = 8'h00;
  localparam logic [4:0] RST_SEL = 5'h00;
  localparam logic [4:0] RST_STRAP = 5'h00;

  // ==========================================================================
  // Frequency arithmetic; frequencies are carried in units of 10 Hz
  localparam logic [23:0] GEAR_10HZ = 24'h49_40E5;
  localparam logic [31:0] UNITS_PER_MHZ = 32'h0001_86A0;
  localparam logic [31:0] PROG_MIN_MHZ = 32'h0000_0032;
  localparam logic [31:0] PROG_MAX_MHZ = 32'h0000_00F8;
  localparam logic [31:0] PROG_MIN_10HZ = PROG_MIN_MHZ * UNITS_PER_MHZ;
  localparam logic [31:0] PROG_MAX_10HZ = PROG_MAX_MHZ * UNITS_PER_MHZ;
  // Table entries are in 0.1 MHz steps
  localparam logic [31:0] TABLE_SCALE = 32'h0000_2710;

  // ==========================================================================
  // Load engine states
  typedef enum logic [1:0] {
    PFS_IDLE,
    PFS_DIV_CPU,
    PFS_DIV_MID,
    PFS_DIV_PCI
  } pfs_state_t;

endpackage

// ### core/pfs_sel_if.sv
// Select code lookup carrier between the frequency core and its table
`timescale 1ns/10ps
interface pfs_sel_if;
  logic [4:0] code;
  logic [11:0] cpu;
  logic [11:0] mid;
  logic [11:0] pci;
  logic reserved;

  modport table_side (input code, output cpu, output mid, output pci, output reserved);
  modport user_side (output code, input cpu, input mid, input pci, input reserved);
endinterface

// ### core/pfs_sel_decode.sv
// Fixed 32-entry select code table (CPU, mid-speed group, PCI in 0.1 MHz)
`timescale 1ns/10ps
module pfs_sel_decode
  import pfs_pkg::*;
(
  // Lookup
  pfs_sel_if.table_side sel
);

  // ==========================================================================
  // Table lookup; reserved codes return zeros with the reserved flag
  function automatic logic [36:0] lookup(input logic [4:0] code);
    logic [36:0] r;
    r = {1'b0, 12'd0, 12'd0, 12'd0};
    case (code)
      5'h00: r = {1'b0, 12'd1560, 12'd780, 12'd390};
      5'h01: r = {1'b0, 12'd1540, 12'd770, 12'd385};
      5'h02: r = {1'b0, 12'd1520, 12'd760, 12'd380};
      5'h03: r = {1'b0, 12'd1470, 12'd735, 12'd368};
      5'h04: r = {1'b0, 12'd1440, 12'd720, 12'd360};
      5'h05: r = {1'b0, 12'd1420, 12'd710, 12'd355};
      5'h06: r = {1'b0, 12'd1380, 12'd690, 12'd345};
      5'h07: r = {1'b0, 12'd1360, 12'd680, 12'd340};
      5'h08: r = {1'b0, 12'd1240, 12'd620, 12'd310};
      5'h09: r = {1'b0, 12'd1220, 12'd610, 12'd305};
      5'h0A: r = {1'b0, 12'd1170, 12'd780, 12'd390};
      5'h0B: r = {1'b0, 12'd1150, 12'd767, 12'd383};
      5'h0C: r = {1'b0, 12'd1130, 12'd753, 12'd377};
      5'h0D: r = {1'b0, 12'd1080, 12'd720, 12'd360};
      5'h0E: r = {1'b0, 12'd1050, 12'd700, 12'd350};
      5'h0F: r = {1'b0, 12'd1020, 12'd680, 12'd340};
      5'h10, 5'h11, 5'h12: r = {1'b1, 12'd0, 12'd0, 12'd0};
      5'h13: r = {1'b0, 12'd2000, 12'd666, 12'd333};
      5'h14: r = {1'b0, 12'd1900, 12'd760, 12'd380};
      5'h15: r = {1'b0, 12'd1800, 12'd720, 12'd360};
      5'h16: r = {1'b0, 12'd1700, 12'd680, 12'd340};
      5'h17: r = {1'b0, 12'd1500, 12'd750, 12'd375};
      5'h18: r = {1'b0, 12'd1400, 12'd700, 12'd350};
      5'h19: r = {1'b0, 12'd1200, 12'd600, 12'd300};
      5'h1A: r = {1'b0, 12'd1100, 12'd733, 12'd333};
      5'h1B: r = {1'b0, 12'd666, 12'd666, 12'd333};
      5'h1C: r = {1'b0, 12'd2000, 12'd666, 12'd333};
      5'h1D: r = {1'b0, 12'd1666, 12'd666, 12'd333};
      5'h1E: r = {1'b0, 12'd1000, 12'd666, 12'd333};
      default: r = {1'b0, 12'd1333, 12'd666, 12'd333};
    endcase
    return r;
  endfunction

  // Every defined code shares one gear constant, so only the three 0.1 MHz frequencies live here
  assign {sel.reserved, sel.cpu, sel.mid, sel.pci} = lookup(sel.code); // see RULE8

endmodule

// ### core/pfs_core.sv
// Programmable CPU frequency select: control bytes, strap latch, load engine
//
// Contract
// RULE1 - With enable set, CPU frequency comes from the N and M divider values.
// RULE2 - A write to the M divider byte starts loading a new frequency.
// RULE3 - Output ratio comes from latched strap code, or select field under override.
// RULE4 - Enable sits in M byte bit 7, resets 0; 1 enables programming.
// RULE5 - N byte and M divider bits reset to zero.
// RULE6 - Host writes ones to reserved byte A bits 1:0; those reset to one.
// RULE7 - Reserved bytes B and C reset to zero and do nothing.
// RULE8 - Select code decodes through fixed table; codes 10000-10010 reserved.
// RULE9 - Programmed CPU frequency is accepted only within 50 to 248 MHz.
// RULE10 - With enable clear, frequency follows strap code or select field.
// RULE11 - Host should update N and M in one transfer to skip intermediates; the host model writes N then M as two byte writes.
// RULE12 - Programmed CPU frequency is gear constant times N divided by M.
`timescale 1ns/10ps
module pfs_core
  import pfs_pkg::*;
#(
  parameter int unsigned DIV_W = 40
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // Register byte port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // Strap inputs
  input wire logic [4:0] strap_code_i,
  // Frequency outputs, 10 Hz units
  output logic [31:0] cpu_freq_o,
  output logic [31:0] mid_freq_o,
  output logic [31:0] pci_freq_o,
  output logic [23:0] gear_const_o,
  // Status
  output logic [4:0] active_code_o,
  output logic prog_active_o,
  output logic code_reserved_o,
  output logic load_busy_o,
  output logic range_error_o,
  output logic freq_update_o
);

  // ==========================================================================
  // Parameter check: dividend must hold CPU result times a table entry
  if (DIV_W < 38) begin : g_bad_width
    $error("pfs_core: DIV_W must be at least 38");
  end

  // ==========================================================================
  // Register state
  logic [7:0] div_n, next_div_n;
  logic [6:0] div_m, next_div_m;
  logic prog_en, next_prog_en;
  logic [7:0] rsvd_a, next_rsvd_a;
  logic [7:0] rsvd_b, next_rsvd_b;
  logic [7:0] rsvd_c, next_rsvd_c;
  logic strap_override, next_strap_override;
  logic [4:0] sel_code, next_sel_code;
  logic [4:0] latched_strap_code, next_latched_strap_code;
  logic strap_taken, next_strap_taken;
  logic [7:0] next_rdata;
  logic m_written;

  // ==========================================================================
  // Load engine and output state
  pfs_state_t state, next_state;
  logic [5:0] step, next_step;
  logic [DIV_W-1:0] quot, next_quot;
  logic [12:0] rem, next_rem;
  logic [11:0] dvsr, next_dvsr;
  logic [31:0] cand_cpu, next_cand_cpu;
  logic [31:0] cand_mid, next_cand_mid;
  logic [31:0] prog_cpu, next_prog_cpu;
  logic [31:0] prog_mid, next_prog_mid;
  logic [31:0] prog_pci, next_prog_pci;
  logic prog_valid, next_prog_valid;
  logic next_range_error;
  logic next_freq_update;
  logic [31:0] next_cpu_freq, next_mid_freq, next_pci_freq;
  logic [23:0] next_gear;
  logic [13:0] trial;
  logic [13:0] trial_sub;
  logic [DIV_W-1:0] shifted;

  // Table lookup of the active code
  pfs_sel_if sel_bus ();
  pfs_sel_decode u_decode (
    .sel(sel_bus)
  );

  // Override picks the programmed select field over the strap code
  assign sel_bus.code = strap_override ? sel_code : latched_strap_code; // see RULE3 see RULE10

  // Table entry scaled from 0.1 MHz to 10 Hz
  function automatic logic [31:0] to_10hz(input logic [11:0] tenths);
    return 32'(tenths) * TABLE_SCALE;
  endfunction

  // Reading a register as the bus sees it
  function automatic logic [7:0] read_reg(input logic [7:0] addr, input logic [7:0] n,
                                          input logic [7:0] m, input logic [7:0] a,
                                          input logic [7:0] b, input logic [7:0] c,
                                          input logic [7:0] ctrl);
    logic [7:0] d;
    d = 8'h00;
    if (addr == OFS_DIV_N) begin
      d = n;
    end else if (addr == OFS_DIV_M) begin
      d = m;
    end else if (addr == OFS_RSVD_A) begin
      d = a;
    end else if (addr == OFS_RSVD_B) begin
      d = b;
    end else if (addr == OFS_RSVD_C) begin
      d = c;
    end else if (addr == OFS_SEL_CTRL) begin
      d = ctrl;
    end
    return d;
  endfunction

  // ==========================================================================
  // Register file next values
  always_comb begin
    next_div_n = div_n;
    next_div_m = div_m;
    next_prog_en = prog_en;
    next_rsvd_a = rsvd_a;
    next_rsvd_b = rsvd_b;
    next_rsvd_c = rsvd_c;
    next_strap_override = strap_override;
    next_sel_code = sel_code;
    m_written = 1'b0;
    // Straps are caught once, on the first edge after reset release
    next_strap_taken = 1'b1;
    next_latched_strap_code = strap_taken ? latched_strap_code : strap_code_i;
    if (reg_wr_i) begin
      if (reg_addr_i == OFS_DIV_N) begin
        next_div_n = reg_wdata_i;
      end else if (reg_addr_i == OFS_DIV_M) begin
        next_prog_en = reg_wdata_i[POS_PROG_EN]; // see RULE4
        next_div_m = reg_wdata_i[6:0];
        m_written = 1'b1;
      end else if (reg_addr_i == OFS_RSVD_A) begin
        // Stored only; host is expected to keep bits 1:0 at one
        next_rsvd_a = reg_wdata_i; // see RULE6
      end else if (reg_addr_i == OFS_RSVD_B) begin
        next_rsvd_b = reg_wdata_i; // see RULE7
      end else if (reg_addr_i == OFS_RSVD_C) begin
        next_rsvd_c = reg_wdata_i; // see RULE7
      end else if (reg_addr_i == OFS_SEL_CTRL) begin
        next_strap_override = reg_wdata_i[POS_OVERRIDE];
        next_sel_code = reg_wdata_i[4:0];
      end
    end
    next_rdata = reg_rd_i ? read_reg(reg_addr_i, div_n, {prog_en, div_m}, rsvd_a, rsvd_b,
                                     rsvd_c, {strap_override, load_busy_o, range_error_o,
                                     sel_code}) : reg_rdata_o;
  end

  // Register file flops
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_n <= RST_DIV_N; // see RULE5
      div_m <= RST_DIV_M[6:0]; // see RULE5
      prog_en <= RST_DIV_M[POS_PROG_EN]; // see RULE4
      rsvd_a <= RST_RSVD_A; // see RULE6
      rsvd_b <= RST_RSVD_B; // see RULE7
      rsvd_c <= RST_RSVD_C; // see RULE7
      strap_override <= 1'b0;
      sel_code <= RST_SEL;
      latched_strap_code <= RST_STRAP;
      strap_taken <= 1'b0;
      reg_rdata_o <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      div_n <= next_div_n;
      div_m <= next_div_m;
      prog_en <= next_prog_en;
      rsvd_a <= next_rsvd_a;
      rsvd_b <= next_rsvd_b;
      rsvd_c <= next_rsvd_c;
      strap_override <= next_strap_override;
      sel_code <= next_sel_code;
      latched_strap_code <= next_latched_strap_code;
      strap_taken <= next_strap_taken;
      reg_rdata_o <= next_rdata;
      reg_rvalid_o <= reg_rd_i;
    end
  end

  // ==========================================================================
  // Restoring divider step shared by the three divisions
  assign shifted = {quot[DIV_W-2:0], 1'b0};
  assign trial = {rem, quot[DIV_W-1]};
  assign trial_sub = trial - {2'b00, dvsr};

  // Load engine: CPU = G*N/M, then mid and PCI keep the table ratio
  always_comb begin
    next_state = state;
    next_step = step;
    next_quot = quot;
    next_rem = rem;
    next_dvsr = dvsr;
    next_cand_cpu = cand_cpu;
    next_cand_mid = cand_mid;
    next_prog_cpu = prog_cpu;
    next_prog_mid = prog_mid;
    next_prog_pci = prog_pci;
    next_prog_valid = prog_valid && prog_en;
    next_range_error = range_error_o;
    next_freq_update = 1'b0;
    if (state != PFS_IDLE) begin
      next_quot = {shifted[DIV_W-1:1], ~trial_sub[13]};
      next_rem = trial_sub[13] ? trial[12:0] : trial_sub[12:0];
      next_step = step - 6'd1;
    end
    case (state)
      PFS_IDLE: begin
      end
      PFS_DIV_CPU: begin
        if (step == 6'd1) begin
          next_cand_cpu = next_quot[31:0];
          // Out-of-range results are dropped and the old frequency stays
          if (next_quot >= DIV_W'(PROG_MIN_10HZ) && next_quot <= DIV_W'(PROG_MAX_10HZ) &&
              !sel_bus.reserved) begin // see RULE9
            next_state = PFS_DIV_MID;
            next_quot = DIV_W'(next_quot[24:0]) * DIV_W'(sel_bus.mid);
            next_rem = 13'd0;
            next_dvsr = sel_bus.cpu;
            next_step = 6'(DIV_W);
          end else begin
            next_state = PFS_IDLE;
            next_range_error = 1'b1;
          end
        end
      end
      PFS_DIV_MID: begin
        if (step == 6'd1) begin
          next_cand_mid = next_quot[31:0];
          next_state = PFS_DIV_PCI;
          next_quot = DIV_W'(cand_cpu[24:0]) * DIV_W'(sel_bus.pci);
          next_rem = 13'd0;
          next_step = 6'(DIV_W);
        end
      end
      default: begin
        if (step == 6'd1) begin
          next_prog_cpu = cand_cpu;
          next_prog_mid = cand_mid;
          next_prog_pci = next_quot[31:0];
          next_prog_valid = 1'b1;
          next_freq_update = 1'b1;
          next_state = PFS_IDLE;
        end
      end
    endcase
    // A new nonzero M value restarts the load, even one in progress; a zero M stops it
    if (m_written) begin // see RULE2
      if (next_div_m == 7'd0) begin
        next_state = PFS_IDLE;
        next_range_error = 1'b1;
      end else begin
        next_state = PFS_DIV_CPU;
        next_quot = DIV_W'(GEAR_10HZ) * DIV_W'(next_div_n); // see RULE12
        next_rem = 13'd0;
        next_dvsr = {5'd0, next_div_m}; // see RULE12
        next_step = 6'(DIV_W);
        next_range_error = 1'b0;
      end
    end
    // Output selection; a reserved code in table mode holds the last outputs
    next_cpu_freq = cpu_freq_o;
    next_mid_freq = mid_freq_o;
    next_pci_freq = pci_freq_o;
    next_gear = gear_const_o;
    if (prog_en) begin
      if (prog_valid) begin
        next_cpu_freq = prog_cpu; // see RULE1
        next_mid_freq = prog_mid; // see RULE3
        next_pci_freq = prog_pci;
        next_gear = GEAR_10HZ;
      end
    end else if (!sel_bus.reserved) begin
      next_cpu_freq = to_10hz(sel_bus.cpu); // see RULE10 see RULE8
      next_mid_freq = to_10hz(sel_bus.mid);
      next_pci_freq = to_10hz(sel_bus.pci);
      next_gear = GEAR_10HZ;
    end
  end

  // Load engine and output flops
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= PFS_IDLE;
      step <= 6'd0;
      quot <= '0;
      rem <= 13'd0;
      dvsr <= 12'd0;
      cand_cpu <= 32'd0;
      cand_mid <= 32'd0;
      prog_cpu <= 32'd0;
      prog_mid <= 32'd0;
      prog_pci <= 32'd0;
      prog_valid <= 1'b0;
      range_error_o <= 1'b0;
      freq_update_o <= 1'b0;
      cpu_freq_o <= 32'd0;
      mid_freq_o <= 32'd0;
      pci_freq_o <= 32'd0;
      gear_const_o <= 24'd0;
    end else begin
      state <= next_state;
      step <= next_step;
      quot <= next_quot;
      rem <= next_rem;
      dvsr <= next_dvsr;
      cand_cpu <= next_cand_cpu;
      cand_mid <= next_cand_mid;
      prog_cpu <= next_prog_cpu;
      prog_mid <= next_prog_mid;
      prog_pci <= next_prog_pci;
      prog_valid <= next_prog_valid;
      range_error_o <= next_range_error;
      freq_update_o <= next_freq_update;
      cpu_freq_o <= next_cpu_freq;
      mid_freq_o <= next_mid_freq;
      pci_freq_o <= next_pci_freq;
      gear_const_o <= next_gear;
    end
  end

  // Status straight from state
  assign active_code_o = sel_bus.code;
  assign code_reserved_o = sel_bus.reserved;
  assign prog_active_o = prog_en && prog_valid;
  assign load_busy_o = (state != PFS_IDLE);

endmodule

// ### test/pfs_host_model.sv
// Host model driving byte strobes on the register port
`timescale 1ns/10ps
module pfs_host_model import pfs_pkg::*; (
  // Clock
  input wire logic clk_sys_i,
  // Register port, host side
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  input wire logic [7:0] reg_rdata_i,
  input wire logic reg_rvalid_i
);
  // ==========
  // Bus cycles
  initial begin
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end
  // Released lines show the inverse, so stale values cannot pass
  task automatic idle();
    reg_wr_o <= 1'b0;
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~reg_addr_o;
    reg_wdata_o <= ~reg_wdata_o;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge clk_sys_i);
    idle();
  endtask
  // N then M two edges apart; only the M write starts a load, so no intermediate value loads
  task automatic wr_nm(input logic [7:0] n, input logic [7:0] m);
    wr(OFS_DIV_N, n);
    wr(OFS_DIV_M, m);
  endtask
  // Low two bits of the first reserved byte always go out as ones
  task automatic keep_rsvd_a(input logic [7:0] d);
    wr(OFS_RSVD_A, d | 8'h03);
  endtask
  // Data is taken once the answer edge has settled
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk_sys_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge clk_sys_i);
    idle();
    #1;
    v = reg_rvalid_i;
    d = reg_rdata_i;
  endtask
endmodule

// ### test/pfs_core_chk.sv
// Port-level assertions for the frequency select core
`timescale 1ns/10ps
module pfs_core_chk import pfs_pkg::*; #(
  parameter int unsigned DIV_W = 40
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic reg_rvalid_o,
  // Straps and status
  input wire logic [4:0] strap_code_i,
  input wire logic [31:0] cpu_freq_o,
  input wire logic [23:0] gear_const_o,
  input wire logic [4:0] active_code_o,
  input wire logic prog_active_o,
  input wire logic code_reserved_o,
  input wire logic load_busy_o,
  input wire logic range_error_o,
  input wire logic freq_update_o
);
  localparam int LOAD_CYC = 3 * DIV_W;
  logic m_wr, m_nz, got, en_h, ovr_h;
  logic [4:0] strap_h, sel_h;
  // ==========
  // Shadow of mode bits
  assign m_wr = reg_wr_i && (reg_addr_i == OFS_DIV_M);
  assign m_nz = m_wr && (reg_wdata_i[6:0] != 7'h00);
  // Strap is caught on the first edge out of reset only
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      got <= 1'b0;
      strap_h <= 5'h00;
      en_h <= 1'b0;
      ovr_h <= 1'b0;
      sel_h <= 5'h00;
    end else begin
      got <= 1'b1;
      if (!got) strap_h <= strap_code_i;
      if (m_wr) en_h <= reg_wdata_i[POS_PROG_EN];
      if (reg_wr_i && (reg_addr_i == OFS_SEL_CTRL)) begin
        ovr_h <= reg_wdata_i[POS_OVERRIDE];
        sel_h <= reg_wdata_i[4:0];
      end
    end
  end
  // ==========
  // Assertions
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  a_read_answer: assert property (reg_rd_i ##1 !reg_rd_i |-> reg_rvalid_o ##1 !reg_rvalid_o)
    else $error("read answer missing or too long");
  a_load_start: assert property (m_nz |=> load_busy_o && !range_error_o)
    else $error("M write did not start a load");
  // Commit pulse is registered on the edge of the last divider step and seen one edge later, engine already idle
  a_load_length: assert property (freq_update_o |-> $past(m_nz, LOAD_CYC + 1) && !load_busy_o)
    else $error("commit not at the fixed load length");
  a_update_pulse: assert property (freq_update_o |=> !freq_update_o)
    else $error("commit pulse longer than one cycle");
  a_mzero_reject: assert property (m_wr && !m_nz |=> range_error_o && !load_busy_o)
    else $error("zero M divider not rejected");
  a_prog_range: assert property (freq_update_o && en_h |=>
    cpu_freq_o >= PROG_MIN_10HZ && cpu_freq_o <= PROG_MAX_10HZ)
    else $error("programmed CPU frequency out of range");
  a_code_select: assert property (active_code_o == (ovr_h ? sel_h : strap_h))
    else $error("active code from wrong source");
  a_code_rsvd: assert property (code_reserved_o == (active_code_o inside {[5'h10:5'h12]}))
    else $error("reserved code flag wrong");
  a_gear_const: assert property (gear_const_o != 24'h00_0000 |-> gear_const_o == GEAR_10HZ)
    else $error("gear constant wrong");
  a_prog_enable: assert property (prog_active_o |-> en_h)
    else $error("programmed mode without enable");
  c_commit: cover property (freq_update_o);
  c_rsvd_code: cover property (code_reserved_o);
  c_mzero: cover property (m_wr && !m_nz);
endmodule
bind pfs_core pfs_core_chk #(.DIV_W(DIV_W)) u_pfs_core_chk (
  .clk_sys_i(clk_sys_i),
  .nrst_i(nrst_i),
  .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i),
  .reg_rvalid_o(reg_rvalid_o),
  .strap_code_i(strap_code_i),
  .cpu_freq_o(cpu_freq_o),
  .gear_const_o(gear_const_o),
  .active_code_o(active_code_o),
  .prog_active_o(prog_active_o),
  .code_reserved_o(code_reserved_o),
  .load_busy_o(load_busy_o),
  .range_error_o(range_error_o),
  .freq_update_o(freq_update_o)
);

// ### test/programmable_cpu_freq_select_tb.sv
// Self-checking bench for the programmable CPU frequency select core
`timescale 1ns/10ps
module programmable_cpu_freq_select_tb import pfs_pkg::*; ;
  logic clk_sys_i, nrst_i, wr, rd, rvalid, prog_act, code_rsvd, busy, rng_err, upd;
  logic [4:0] strap, code;
  logic [7:0] addr, wdata, rdata;
  logic [31:0] cpu_f, mid_f, pci_f;
  logic [23:0] gear;
  logic [63:0] e_last;
  int n_fail = 0;
  int cmp_count = 0;
  // Select codes under test and their entries in 0.1 MHz
  localparam logic [4:0] TC [6] = '{5'h00, 5'h0A, 5'h0B, 5'h13, 5'h1B, 5'h1F};
  localparam logic [11:0] TCPU [6] = '{12'h618, 12'h492, 12'h47E, 12'h7D0, 12'h29A, 12'h535};
  localparam logic [11:0] TMID [6] = '{12'h30C, 12'h30C, 12'h2FF, 12'h29A, 12'h29A, 12'h29A};
  localparam logic [11:0] TPCI [6] = '{12'h186, 12'h186, 12'h17F, 12'h14D, 12'h14D, 12'h14D};
  localparam logic [7:0] RA [7] = '{8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h20};
  localparam logic [7:0] RV [7] = '{8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00};
  // ==========
  // Design and host
  pfs_core #(.DIV_W(40)) u_pfs_core (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .strap_code_i(strap), .cpu_freq_o(cpu_f),
    .mid_freq_o(mid_f), .pci_freq_o(pci_f), .gear_const_o(gear), .active_code_o(code),
    .prog_active_o(prog_act), .code_reserved_o(code_rsvd), .load_busy_o(busy),
    .range_error_o(rng_err), .freq_update_o(upd));
  pfs_host_model u_pfs_host_model (.clk_sys_i(clk_sys_i), .reg_addr_o(addr),
    .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd), .reg_rdata_i(rdata),
    .reg_rvalid_i(rvalid));
  // ==========
  // Checking helpers
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk_tbl(input int i);
    chk("cpu_freq", 32'(TCPU[i]) * TABLE_SCALE, cpu_f);
    chk("mid_freq", 32'(TMID[i]) * TABLE_SCALE, mid_f);
    chk("pci_freq", 32'(TPCI[i]) * TABLE_SCALE, pci_f);
  endtask
  // Load with strap ratio of code 0x1F; commit counted from the M edge
  task automatic prog_load(input logic [7:0] nv, input logic [6:0] mv);
    int n;
    u_pfs_host_model.wr_nm(nv, {1'b1, mv});
    n = 1;
    #1;
    while (upd !== 1'b1 && n < 200) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    chk("load_cycles", 121, n);
    @(posedge clk_sys_i);
    #1;
    e_last = 64'(GEAR_10HZ) * 64'(nv) / 64'(mv);
    chk("cpu_prog", e_last[31:0], cpu_f);
    chk("mid_prog", 32'(e_last * 12'h29A / 12'h535), mid_f);
    chk("pci_prog", 32'(e_last * 12'h14D / 12'h535), pci_f);
    chk("prog_active", 1, prog_act);
    chk("gear", 32'(GEAR_10HZ), 32'(gear));
    chk("range_err", 0, rng_err);
  endtask
  task automatic complete_run();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Cuts a hang well past the expected run length
  initial begin
    #20000;
    n_fail++;
    complete_run();
  end
  // ==========
  // Main sequence
  initial begin
    logic [7:0] d;
    logic v;
    int seen;
    nrst_i = 1'b0;
    strap = 5'h1F;
    repeat (10) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    #1;
    chk_tbl(5);
    u_pfs_host_model.wr(8'h20, 8'hFF);
    foreach (RA[i]) begin
      u_pfs_host_model.rd(RA[i], d, v);
      chk("rvalid", 1, v);
      chk("reg_reset", 32'(RV[i]), 32'(d));
    end
    u_pfs_host_model.wr(OFS_RSVD_B, 8'h5A);
    u_pfs_host_model.keep_rsvd_a(8'h00);
    u_pfs_host_model.rd(OFS_RSVD_B, d, v);
    chk("rsvd_b", 32'h0000_005A, 32'(d));
    chk_tbl(5);
    for (int i = 0; i < 6; i++) begin
      u_pfs_host_model.wr(OFS_SEL_CTRL, {3'b100, TC[i]});
      repeat (2) @(posedge clk_sys_i);
      #1;
      chk("active_code", 32'(TC[i]), 32'(code));
      chk_tbl(i);
    end
    // Reserved code keeps the last entry
    u_pfs_host_model.wr(OFS_SEL_CTRL, 8'h90);
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk("code_reserved", 1, code_rsvd);
    chk_tbl(5);
    u_pfs_host_model.wr(OFS_SEL_CTRL, 8'h00);
    prog_load(8'h32, 7'h10);
    // N alone must not load
    u_pfs_host_model.wr(OFS_DIV_N, 8'h40);
    seen = 0;
    repeat (130) begin
      @(posedge clk_sys_i);
      if (upd === 1'b1 || busy === 1'b1) seen = 1;
    end
    chk("n_only_load", 0, seen);
    // Out of range result is refused and the old value kept
    u_pfs_host_model.wr_nm(8'hC8, 8'h82);
    repeat (45) @(posedge clk_sys_i);
    #1;
    chk("range_err", 1, rng_err);
    chk("cpu_kept", e_last[31:0], cpu_f);
    prog_load(8'h64, 7'h28);
    u_pfs_host_model.wr(OFS_DIV_M, 8'h80);
    #1;
    chk("mzero_err", 1, rng_err);
    chk("mzero_busy", 0, busy);
    u_pfs_host_model.rd(OFS_SEL_CTRL, d, v);
    chk("ctrl_status", 32'h0000_0020, 32'(d));
    // Enable cleared: back to strap table
    u_pfs_host_model.wr(OFS_DIV_M, 8'h10);
    repeat (125) @(posedge clk_sys_i);
    #1;
    chk("prog_off", 0, prog_act);
    chk_tbl(5);
    complete_run();
  end
endmodule
